/* File: design/smp_mem.sv */
`timescale 1ns/1ps
// Single write port, single read port; read data come from a register
module smp_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_reg
);

    logic [DW-1:0] mem [2**AW];

    // Array has no reset: contents persist like the cells they model
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= mem[raddr];
        end
    end

endmodule : smp_mem

/* File: design/smp_port.sv */
`timescale 1ns/1ps
module smp_port
    import smp_pkg::*;
#(
    parameter logic [SMP_DLY_W-1:0] FLASH_WD_CYC = SMP_FLASH_WD_CYC,
    parameter logic [SMP_DLY_W-1:0] EEPROM_WD_CYC = SMP_EEPROM_WD_CYC,
    parameter logic [SMP_DLY_W-1:0] ERASE_WD_CYC = SMP_ERASE_WD_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Programming pins
    input wire logic reset_pin_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Status to the rest of the chip
    output logic prog_mode,
    output logic busy_poll_flag
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    smp_state_t s;
    smp_state_t n;
    logic prog;
    logic rise;
    logic fall;
    logic [31:0] sh_n;
    logic byte_done;
    logic [7:0] new_byte;
    logic push;
    logic pop;
    logic buf_ready;
    smp_instr_t head;
    logic fl_we;
    logic [SMP_FL_AW-1:0] fl_waddr;
    logic [7:0] fl_wdata;
    logic [SMP_FL_AW-1:0] fl_raddr;
    logic [7:0] fl_rdata;
    logic ee_we;
    logic [SMP_EE_AW-1:0] ee_waddr;
    logic [7:0] ee_wdata;
    logic [SMP_EE_AW-1:0] ee_raddr;
    logic [7:0] ee_rdata;
    logic pb_we;
    logic [SMP_PB_AW-1:0] pb_waddr;
    logic [SMP_PB_AW-1:0] pb_raddr;
    logic [7:0] pb_rdata;
    logic [SMP_PB_AW-1:0] idx;

    // Word address plus high/low select gives the flash byte address
    function automatic logic [SMP_FL_AW-1:0] flash_byte(
        input logic [SMP_PROGRAM_COUNTER_TOP_BIT:0] word,
        input logic hi
    );
        flash_byte = {word, hi};
    endfunction : flash_byte

    // ----------------------------------------------------------------
    // Memories
    // ----------------------------------------------------------------
    smp_mem #(.AW(SMP_FL_AW), .DW(8)) u_flash (
        .clock(clock), .nrst(nrst), .we(fl_we), .waddr(fl_waddr),
        .wdata(fl_wdata), .raddr(fl_raddr), .rdata_reg(fl_rdata)
    );
    smp_mem #(.AW(SMP_EE_AW), .DW(8)) u_eeprom (
        .clock(clock), .nrst(nrst), .we(ee_we), .waddr(ee_waddr),
        .wdata(ee_wdata), .raddr(ee_raddr), .rdata_reg(ee_rdata)
    );
    smp_mem #(.AW(SMP_PB_AW), .DW(8)) u_page_buf (
        .clock(clock), .nrst(nrst), .we(pb_we), .waddr(pb_waddr),
        .wdata(head.b4), .raddr(pb_raddr), .rdata_reg(pb_rdata)
    );

    // ----------------------------------------------------------------
    // Link edges and shift helpers
    // ----------------------------------------------------------------
    // Only the second stage of each synchroniser is read here
    assign prog = !s.rst_s[1];
    assign rise = prog && s.sck_s[1] && !s.sck_d;
    assign fall = prog && !s.sck_s[1] && s.sck_d;
    assign sh_n = {s.shf[30:0], s.mosi_s[1]};
    assign new_byte = sh_n[7:0];
    assign byte_done = rise && (s.bitc == SMP_LAST_BIT);
    assign head = s.fifo[0];
    // Two-entry buffer: the executor stalls during copy and erase
    assign buf_ready = (s.fcnt != SMP_BUF_DEPTH) || pop;
    assign pop = prog && (s.fcnt != 2'h0)
        && (s.exec == SMP_IDLE || s.exec == SMP_WAIT);
    assign push = byte_done && (s.bytec == SMP_BYTE_LAST) && buf_ready;
    assign idx = SMP_PB_AW'(s.cnt - 13'h0001);
    // Host reads use the address bytes held in the shifter
    assign fl_raddr = flash_byte(s.shf[SMP_PROGRAM_COUNTER_TOP_BIT:0],
        s.shf[23:16] == SMP_OP_RD_FHI);
    assign ee_raddr = s.shf[SMP_EE_AW-1:0];
    assign pb_raddr = s.cnt[SMP_PB_AW-1:0];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        fl_we = 1'b0;
        fl_waddr = '0;
        fl_wdata = SMP_ERASED;
        ee_we = 1'b0;
        ee_waddr = '0;
        ee_wdata = SMP_ERASED;
        pb_we = 1'b0;
        pb_waddr = '0;
        n.rst_s = {s.rst_s[0], reset_pin_n};
        n.sck_s = {s.sck_s[0], sck};
        n.mosi_s = {s.mosi_s[0], mosi};
        n.sck_d = s.sck_s[1];
        n.rd_stage = {s.rd_stage[0], 1'b0};

        // Serial shifter: byte boundary reloads the echo byte
        if (rise) begin
            n.shf = sh_n;
            n.bitc = 3'(s.bitc + 3'h1);
            if (byte_done) begin
                n.bytec = 2'(s.bytec + 2'h1);
                n.tx = new_byte;
                if (s.bytec == SMP_BYTE_DATA) begin
                    if (sh_n[23:16] == SMP_OP_POLL) begin
                        n.tx = '0;
                        n.tx[SMP_BUSY_BIT] = busy_poll_flag;
                    end
                    if (sh_n[23:16] == SMP_OP_RD_FLO
                        || sh_n[23:16] == SMP_OP_RD_FHI
                        || sh_n[23:16] == SMP_OP_RD_EE) begin
                        n.rd_stage = 2'h1;
                    end
                end
            end
        end
        // First falling edge of a byte presents its MSB
        if (fall) begin
            n.miso = s.tx[7];
            n.tx = {s.tx[6:0], 1'b0};
        end
        // Read data land one cycle after the address is presented
        if (s.rd_stage[1]) begin
            n.tx = (s.shf[23:16] == SMP_OP_RD_EE) ? ee_rdata : fl_rdata;
        end

        // Instruction buffer
        if (pop) begin
            n.fifo[0] = s.fifo[1];
            n.fcnt = 2'(n.fcnt - 2'h1);
        end
        if (push) begin
            n.fifo[n.fcnt[0]] = sh_n;
            n.fcnt = 2'(n.fcnt + 2'h1);
        end

        // Executor
        unique case (s.exec)
            SMP_IDLE: begin
                if (pop && head.op == SMP_OP_AC
                    && head.b2 == SMP_B2_ENABLE) begin
                    n.enabled = 1'b1;
                end else if (pop && s.enabled) begin
                    if (head.op == SMP_OP_AC
                        && head.b2 == SMP_B2_ERASE) begin
                        n.exec = SMP_ERASE;
                        n.cnt = '0;
                    end else if (head.op == SMP_OP_LD_FLO
                        || head.op == SMP_OP_LD_FHI) begin
                        pb_we = 1'b1;
                        pb_waddr = {head.b3[SMP_PAGE_WORD_W-1:0],
                            head.op == SMP_OP_LD_FHI};
                        n.fmask[pb_waddr] = 1'b1;
                    end else if (head.op == SMP_OP_LD_EE) begin
                        n.ebuf[head.b3[SMP_EE_PAGE_W-1:0]] = head.b4;
                        n.emask[head.b3[SMP_EE_PAGE_W-1:0]] = 1'b1;
                    end else if (head.op == SMP_OP_WR_FPG) begin
                        n.fpage = {head.b2[3:0],
                            head.b3[7:SMP_PAGE_WORD_W]};
                        n.exec = SMP_PCOPY;
                        n.cnt = '0;
                    end else if (head.op == SMP_OP_WR_EE) begin
                        // Overwrite stands for auto-erase plus program
                        ee_we = 1'b1;
                        ee_waddr = {head.b2[0], head.b3};
                        ee_wdata = head.b4;
                        n.dly = EEPROM_WD_CYC;
                        n.exec = SMP_WAIT;
                    end else if (head.op == SMP_OP_WR_EPG) begin
                        n.epage = {head.b2[0],
                            head.b3[7:SMP_EE_PAGE_W]};
                        n.exec = SMP_ECOPY;
                        n.cnt = '0;
                    end
                end
            end
            SMP_PCOPY: begin
                // Buffer read is registered, so writes trail by one
                n.cnt = 13'(s.cnt + 13'h0001);
                if (s.cnt != 13'h0000) begin
                    fl_we = s.fmask[idx];
                    fl_waddr = flash_byte({s.fpage, idx[SMP_PB_AW-1:1]},
                        idx[0]);
                    fl_wdata = pb_rdata;
                end
                if (s.cnt == SMP_PB_BYTES) begin
                    n.fmask = '0;
                    n.dly = FLASH_WD_CYC;
                    n.exec = SMP_WAIT;
                end
            end
            SMP_ECOPY: begin
                n.cnt = 13'(s.cnt + 13'h0001);
                ee_we = s.emask[s.cnt[SMP_EE_PAGE_W-1:0]];
                ee_waddr = {s.epage, s.cnt[SMP_EE_PAGE_W-1:0]};
                ee_wdata = s.ebuf[s.cnt[SMP_EE_PAGE_W-1:0]];
                if (s.cnt == 13'(SMP_EE_PAGE_BYTES - 1)) begin
                    n.emask = '0;
                    n.dly = EEPROM_WD_CYC;
                    n.exec = SMP_WAIT;
                end
            end
            SMP_ERASE: begin
                // Both arrays swept in parallel, one byte a cycle
                n.cnt = 13'(s.cnt + 13'h0001);
                fl_we = 1'b1;
                fl_waddr = s.cnt;
                ee_we = s.cnt < SMP_EE_BYTES;
                ee_waddr = s.cnt[SMP_EE_AW-1:0];
                if (s.cnt == SMP_FL_LAST) begin
                    n.dly = ERASE_WD_CYC;
                    n.exec = SMP_WAIT;
                end
            end
            SMP_WAIT: begin
                // Writes popped here are dropped: they would corrupt
                n.dly = SMP_DLY_W'(s.dly - 21'h000001);
                if (s.dly <= 21'h000001) begin
                    n.exec = SMP_IDLE;
                end
            end
        endcase

        // Leaving programming mode drops link state; writes finish
        if (!prog) begin
            n.bitc = '0;
            n.bytec = '0;
            n.enabled = 1'b0;
            n.fcnt = '0;
            n.rd_stage = '0;
            n.miso = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.rst_s <= 2'h3;
            s.exec <= SMP_IDLE;
        end else begin
            s <= n;
        end
    end

    // Pin and status outputs
    assign miso = s.miso;
    assign miso_oe = prog;
    assign prog_mode = prog;
    assign busy_poll_flag = (s.exec != SMP_IDLE);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_page_copy;
        (s.exec == SMP_PCOPY) [*8];
    endsequence

    chk_echo_byte: assert property (
        byte_done && s.bytec == SMP_BYTE_ADDR |=> s.tx == $past(new_byte))
        else $error("echo byte not loaded after second byte");
    // Pin still high in the first stage, so the mode stays off next cycle
    chk_idle_link: assert property (
        !prog && s.rst_s[0]
        |=> s.bytec == 2'h0 && s.bitc == 3'h0 && !miso_oe)
        else $error("link active outside programming mode");
    chk_enable_gate: assert property (
        pop && s.exec == SMP_IDLE && !s.enabled
        && !(head.op == SMP_OP_AC && head.b2 == SMP_B2_ENABLE)
        |=> s.exec == SMP_IDLE && !fl_we && !ee_we)
        else $error("operation run before enable");
    chk_rise_sample: assert property (
        rise |=> s.shf[0] == $past(s.mosi_s[1]))
        else $error("data not sampled on rising edge");
    chk_fall_shift: assert property (
        fall && s.rd_stage == 2'h0 |=> miso == $past(s.tx[7]) ##1
        ($stable(miso) || fall || !prog))
        else $error("output not shifted on falling edge");
    chk_erase_ones: assert property (
        s.exec == SMP_ERASE |-> fl_we && fl_wdata == SMP_ERASED
        && (ee_we == (s.cnt < SMP_EE_BYTES)))
        else $error("erase does not write all ones");
    chk_poll_busy: assert property (
        byte_done && s.bytec == SMP_BYTE_DATA
        && sh_n[23:16] == SMP_OP_POLL
        |=> s.tx[SMP_BUSY_BIT] == $past(busy_poll_flag))
        else $error("poll byte does not show busy");
    chk_read_data: assert property (
        s.rd_stage[1] && s.shf[23:16] != SMP_OP_RD_EE
        |=> s.tx == $past(fl_rdata))
        else $error("read data not returned");
    chk_page_commit: assert property (
        pop && s.exec == SMP_IDLE && s.enabled
        && head.op == SMP_OP_WR_FPG |=> s_page_copy ##[50:60]
        s.exec == SMP_WAIT)
        else $error("page write not committed");
    chk_ee_mask: assert property (
        s.exec == SMP_ECOPY && ee_we
        |-> s.emask[s.cnt[SMP_EE_PAGE_W-1:0]])
        else $error("unloaded EEPROM byte altered");
    chk_leave_mode: assert property (
        $rose(s.rst_s[1]) |-> ##1 !s.enabled && !prog_mode)
        else $error("programming mode not left");

endmodule : smp_port

/* File: inc/smp_pkg.sv */
package smp_pkg;

    // ----------------------------------------------------------------
    // Clock and self-timed write delays
    // ----------------------------------------------------------------
    localparam int SMP_CLK_NS = 4;
    localparam int SMP_FLASH_WD_NS = 4500000; // flash_write_delay, 4.5 ms
    localparam int SMP_EEPROM_WD_NS = 4000000; // eeprom_write_delay, 4.0 ms
    localparam int SMP_ERASE_WD_NS = 4000000; // chip_erase_delay, 4.0 ms
    localparam int SMP_DLY_W = 21;
    // Least times, so rounded up to whole cycles
    localparam logic [SMP_DLY_W-1:0] SMP_FLASH_WD_CYC =
        SMP_DLY_W'((SMP_FLASH_WD_NS + SMP_CLK_NS - 1) / SMP_CLK_NS);
    localparam logic [SMP_DLY_W-1:0] SMP_EEPROM_WD_CYC =
        SMP_DLY_W'((SMP_EEPROM_WD_NS + SMP_CLK_NS - 1) / SMP_CLK_NS);
    localparam logic [SMP_DLY_W-1:0] SMP_ERASE_WD_CYC =
        SMP_DLY_W'((SMP_ERASE_WD_NS + SMP_CLK_NS - 1) / SMP_CLK_NS);

    // ----------------------------------------------------------------
    // Memory geometry (largest variant: 32-word pages, 128 pages)
    // ----------------------------------------------------------------
    localparam int SMP_PROGRAM_COUNTER_TOP_BIT = 11;
    localparam int SMP_PAGE_WORD_W = 5;      // page_word_index width
    localparam int SMP_FL_AW = 13;           // flash byte address
    localparam int SMP_PB_AW = 6;            // page buffer byte address
    localparam int SMP_EEPROM_ADDRESS_TOP_BIT = 8;
    localparam int SMP_EE_AW = 9;
    localparam int SMP_EE_PAGE_W = 2;        // 4 bytes per EEPROM page
    localparam int SMP_EE_PAGE_BYTES = 4;
    localparam logic [SMP_FL_AW-1:0] SMP_FL_LAST = 13'h1FFF;
    localparam logic [SMP_FL_AW-1:0] SMP_EE_BYTES = 13'h0200;
    localparam logic [SMP_FL_AW-1:0] SMP_PB_BYTES = 13'h0040;
    localparam logic [7:0] SMP_ERASED = 8'hFF;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0] SMP_OP_AC = 8'hAC;
    localparam logic [7:0] SMP_B2_ENABLE = 8'h53;  // also the sync echo
    localparam logic [7:0] SMP_B2_ERASE = 8'h80;
    localparam logic [7:0] SMP_OP_POLL = 8'hF0;
    localparam logic [7:0] SMP_OP_LD_FLO = 8'h40;
    localparam logic [7:0] SMP_OP_LD_FHI = 8'h48;
    localparam logic [7:0] SMP_OP_LD_EE = 8'hC1;
    localparam logic [7:0] SMP_OP_RD_FLO = 8'h20;
    localparam logic [7:0] SMP_OP_RD_FHI = 8'h28;
    localparam logic [7:0] SMP_OP_RD_EE = 8'hA0;
    localparam logic [7:0] SMP_OP_WR_FPG = 8'h4C;
    localparam logic [7:0] SMP_OP_WR_EE = 8'hC0;
    localparam logic [7:0] SMP_OP_WR_EPG = 8'hC2;
    localparam int SMP_BUSY_BIT = 0;
    localparam logic [2:0] SMP_LAST_BIT = 3'h7;
    localparam logic [1:0] SMP_BYTE_ADDR = 2'h1;  // byte 2 done
    localparam logic [1:0] SMP_BYTE_DATA = 2'h2;  // byte 3 done
    localparam logic [1:0] SMP_BYTE_LAST = 2'h3;
    localparam logic [1:0] SMP_BUF_DEPTH = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } smp_instr_t;

    typedef enum logic [2:0] {
        SMP_IDLE, SMP_PCOPY, SMP_ECOPY, SMP_ERASE, SMP_WAIT
    } smp_exec_t;

    typedef struct packed {
        logic [1:0] rst_s;
        logic [1:0] sck_s;
        logic [1:0] mosi_s;
        logic sck_d;
        logic [2:0] bitc;
        logic [1:0] bytec;
        logic [31:0] shf;
        logic [7:0] tx;
        logic miso;
        logic [1:0] rd_stage;
        logic enabled;
        smp_instr_t [1:0] fifo;
        logic [1:0] fcnt;
        smp_exec_t exec;
        logic [SMP_FL_AW-1:0] cnt;
        logic [SMP_DLY_W-1:0] dly;
        logic [6:0] fpage;
        logic [6:0] epage;
        logic [63:0] fmask;
        logic [3:0] emask;
        logic [3:0][7:0] ebuf;
    } smp_state_t;

endpackage : smp_pkg

/* File: verif/smp_host.sv */
`timescale 1ns/1ps
// Programming host: mode-0 serial master that also owns the reset pin
module smp_host #(
    parameter int HALF_CYC = 20,
    parameter int SETTLE_CYC = 50
) (
    // Clock
    clock,
    // Pins toward the device
    reset_pin_n,
    sck,
    mosi,
    miso,
    // Bytes seen on miso during the last instruction
    rsp,
    rsp_valid
);
    input wire logic clock;
    output logic reset_pin_n;
    output logic sck;
    output logic mosi;
    input wire logic miso;
    output logic [31:0] rsp;
    output logic rsp_valid;

    // -------------------------------------------------------------
    // Pin control
    // -------------------------------------------------------------
    // Reset pin and serial clock low from power-up
    initial begin
        reset_pin_n = 1'b0;
        sck = 1'b0;
        mosi = 1'b0;
        rsp = 32'h0;
        rsp_valid = 1'b0;
    end

    // All pin changes land one step after a clock edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc

    // Settling wait is shortened for simulation
    task automatic set_pin(input logic v);
        reset_pin_n = v;
        wait_cyc(SETTLE_CYC);
    endtask : set_pin

    // Always four whole bytes, MSB first; clock idles low between frames
    task automatic xfer(input logic [31:0] ins);
        for (int i = 31; i >= 0; i--) begin
            mosi = ins[i];
            wait_cyc(HALF_CYC);
            sck = 1'b1;
            rsp = {rsp[30:0], miso};
            wait_cyc(HALF_CYC);
            sck = 1'b0;
        end
        mosi = ~mosi;  // Line carries no data now, so never the last bit
        rsp_valid = 1'b1;
        wait_cyc(1);
        rsp_valid = 1'b0;
    endtask : xfer
endmodule : smp_host

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import smp_pkg::*;
;
    // -------------------------------------------------------------
    // Signals and instances
    // -------------------------------------------------------------
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic reset_pin_n, sck, mosi, miso, miso_oe, prog_mode, busy_poll_flag;
    logic rsp_valid;
    logic [31:0] rsp;
    logic [63:0] notes[$];
    logic [63:0] note;
    logic [7:0] d;
    logic [7:0] fd[4];
    logic [11:0] w;
    logic [7:0] op;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 11;

    // Clock at 250 MHz
    always #2 clock = ~clock;

    // Long EEPROM delay so one poll still finds the write running
    smp_port #(
        .FLASH_WD_CYC(SMP_DLY_W'(40)),
        .EEPROM_WD_CYC(SMP_DLY_W'(3000)),
        .ERASE_WD_CYC(SMP_DLY_W'(30))
    ) i_smp_port (
        .clock(clock), .nrst(nrst), .reset_pin_n(reset_pin_n), .sck(sck),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .prog_mode(prog_mode),
        .busy_poll_flag(busy_poll_flag)
    );
    smp_host i_smp_host (
        .clock(clock), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
        .miso(miso), .rsp(rsp), .rsp_valid(rsp_valid)
    );

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] fl(logic [7:0] op, logic [11:0] w,
                                       logic [7:0] v);
        return {op, 4'h0, w, v};
    endfunction : fl

    function automatic logic [31:0] ee(logic [7:0] op, logic [8:0] a,
                                       logic [7:0] v);
        return {op, 7'h00, a, v};
    endfunction : ee

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Note the expectation first, then run the instruction
    task automatic send(input logic [31:0] ins, input logic [31:0] exp,
                        input logic [31:0] mask);
        notes.push_back({exp & mask, mask});
        i_smp_host.xfer(ins);
    endtask : send

    task automatic rd(input logic [31:0] ins, input logic [7:0] v);
        send(ins, {24'h000000, v}, 32'h000000FF);
    endtask : rd

    // Bounded polling, so a flag stuck high cannot hang the run
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            send({SMP_OP_POLL, 24'h000000}, 32'h0, 32'h0);
            n++;
        end while (rsp[SMP_BUSY_BIT] !== 1'b0 && n < 12);
        check("busy poll", 32'h0, {31'h0, rsp[SMP_BUSY_BIT]});
    endtask : wait_idle

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // Each finished instruction retires the oldest expectation
    always @(posedge clock) begin
        if (rsp_valid === 1'b1) begin
            note = notes.pop_front();
            if (note[31:0] !== 32'h0) begin
                check("miso bytes", note[63:32], rsp & note[31:0]);
            end
        end
    end

    // Cycle ceiling in case the device never answers
    always @(posedge clock) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            give_verdict();
        end
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        #1;
        nrst = 1'b1;
        i_smp_host.wait_cyc(10);
        check("prog_mode", 32'h1, {31'h0, prog_mode});
        check("miso_oe", 32'h1, {31'h0, miso_oe});
        send(ee(SMP_OP_WR_EE, 9'h0A5, 8'h3C), 32'h0, 32'h0);
        check("busy", 32'h0, {31'h0, busy_poll_flag});
        send({SMP_OP_AC, SMP_B2_ENABLE, 16'h0000}, 32'h5300, 32'hFF00);
        send({SMP_OP_AC, SMP_B2_ERASE, 16'h0000}, 32'h0, 32'h0);
        check("busy", 32'h1, {31'h0, busy_poll_flag});
        wait_idle();
        rd(fl(SMP_OP_RD_FLO, 12'h123, 8'h00), SMP_ERASED);
        rd(fl(SMP_OP_RD_FHI, 12'hFFF, 8'h00), SMP_ERASED);
        rd(ee(SMP_OP_RD_EE, 9'h1FF, 8'h00), SMP_ERASED);
        d = 8'($random(seed));
        send(ee(SMP_OP_WR_EE, 9'h0A5, d), 32'h0, 32'h0);
        send({SMP_OP_POLL, 24'h000000}, 32'h1, 32'h1);
        wait_idle();
        rd(ee(SMP_OP_RD_EE, 9'h0A5, 8'h00), d);
        for (int i = 0; i < 4; i++) begin
            fd[i] = 8'($random(seed));
        end
        send(ee(SMP_OP_LD_EE, 9'h041, fd[1]), 32'h0, 32'h0);
        send(ee(SMP_OP_LD_EE, 9'h043, fd[3]), 32'h0, 32'h0);
        send(ee(SMP_OP_WR_EPG, 9'h040, 8'h00), 32'h0, 32'h0);
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            rd(ee(SMP_OP_RD_EE, 9'(64 + i), 8'h00),
               i[0] ? fd[i] : SMP_ERASED);
        end
        // Low then high byte of the first and last word of one page
        for (int i = 0; i < 4; i++) begin
            w = 12'(160 + 31 * (i / 2));
            op = i[0] ? SMP_OP_LD_FHI : SMP_OP_LD_FLO;
            send(fl(op, w, fd[i]), 32'h0, 32'h0);
        end
        send(fl(SMP_OP_WR_FPG, 12'h0A0, 8'h00), 32'h0, 32'h0);
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            w = 12'(160 + 31 * (i / 2));
            op = i[0] ? SMP_OP_RD_FHI : SMP_OP_RD_FLO;
            rd(fl(op, w, 8'h00), fd[i]);
        end
        rd(fl(SMP_OP_RD_FLO, 12'h0C0, 8'h00), SMP_ERASED);
        rd(fl(SMP_OP_RD_FHI, 12'h09F, 8'h00), SMP_ERASED);
        i_smp_host.set_pin(1'b1);
        check("prog_mode", 32'h0, {31'h0, prog_mode});
        check("miso_oe", 32'h0, {31'h0, miso_oe});
        i_smp_host.set_pin(1'b0);
        send(ee(SMP_OP_WR_EE, 9'h0A5, ~d), 32'h0, 32'h0);
        send({SMP_OP_AC, SMP_B2_ENABLE, 16'h0000}, 32'h5300, 32'hFF00);
        rd(ee(SMP_OP_RD_EE, 9'h0A5, 8'h00), d);
        give_verdict();
    end
endmodule : tb_top
